// ### include/ssc_defs.svh
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH
// ==========================================================
// register byte offsets
`define SSC_OFF_STATUS   12'h000
`define SSC_OFF_CON1     12'h004
`define SSC_OFF_CON2     12'h008
`define SSC_OFF_BUF      12'h00C
`define SSC_OFF_ADDR     12'h010
// ==========================================================
// status field positions
`define SSC_ST_SMP       7
`define SSC_ST_CKE       6
`define SSC_ST_DA        5
`define SSC_ST_P         4
`define SSC_ST_S         3
`define SSC_ST_RW        2
`define SSC_ST_UA        1
`define SSC_ST_BF        0
// control one field positions
`define SSC_C1_WRITE_COLLISION      7
`define SSC_C1_OV        6
`define SSC_C1_EN        5
`define SSC_C1_CKP       4
// control two field positions
`define SSC_C2_GENERAL_CALL_ENABLE      7
`define SSC_C2_ACK_RECEIVED_STATUS   6
`define SSC_C2_ACK_VALUE     5
`define SSC_C2_ACK_SEQUENCE_START     4
`define SSC_C2_MASTER_RECEIVE_ENABLE      3
`define SSC_C2_PEN       2
`define SSC_C2_RESTART_REQUEST      1
`define SSC_C2_SEN       0
// ==========================================================
// reset values
`define SSC_RST_STATUS   8'h00
`define SSC_RST_CON1     8'h00
`define SSC_RST_CON2     8'h00
`define SSC_RST_BUF      8'h00
`define SSC_RST_ADDR     8'h00
// ==========================================================
// half-period reload counts (pclk cycles minus one)
`define SSC_RLD_DIV4     9'h001
`define SSC_RLD_DIV16    9'h007
`define SSC_RLD_DIV64    9'h01F
`define SSC_GC_ADDR      8'h00
`endif

// ### include/ssc_pkg.sv
package ssc_pkg;
  // ========================================================
  // operating class decoded from the mode field
  typedef enum logic [2:0] {
    SSC_SPI_MST, SSC_SPI_SLV, SSC_I2C_MST, SSC_I2C_FW, SSC_I2C_SLV, SSC_RSVD
  } ssc_mode_t;

  // events from the shift engine, same clock
  typedef struct packed {
    logic       rx_done;
    logic [7:0] rx_byte;
    logic       byte_is_data;
    logic       tx_done;
    logic       addr_match;
    logic       rw_bit;
    logic       start_det;
    logic       stop_det;
    logic       nack_det;
    logic       ack_seen;
    logic       ack_missing;
    logic       ua_need;
    logic       tx_active;
    logic [4:0] seq_done;
    logic       xfer_done;
    logic       timer_two_pulse;
  } ssc_evt_t;

  // control towards the shift engine and pin muxes
  typedef struct packed {
    ssc_mode_t  mode;
    logic       spi_pins_en;
    logic       ss_pin_used;
    logic       i2c_pins_en;
    logic       ten_bit;
    logic       ss_irq_en;
    logic       sample_at_end;
    logic       slew_limit;
    logic       smbus_thresh;
    logic       shift_act_idle;
    logic       clk_idle_high;
    logic       scl_release;
    logic       stretch_en;
    logic [4:0] seq_req;
    logic       ack_value;
  } ssc_ctl_t;
endpackage

// ### rtl/ssc_ctrl.sv
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "ssc_defs.svh"
// What this block does
// - spi master samples at end or middle
// - i2c: sample bit selects slew limiting
// - edge bit picks shift edge, smbus thresholds
// - data/address flag tracks last byte kind
// - start/stop flags, cleared when disabled
// - slave direction bit until start/stop/nack
// - master: direction bit shows transmit busy
// - update-address flag for ten-bit slave
// - buffer full on receive or i2c transmit
// - write collision set on blocked writes
// - spi slave overflow drops new byte
// - i2c overflow when buffer still full
// - port enable hands pins to port
// - idle clock level or slave clock stretch
// - i2c mode codes decoded, reserved inactive
// - spi slave codes and brg master
// - fixed spi divisors and timer clock
// - general call address raises event
// - ack status, ack sequence sends ack value
// - sequence requests self-clear when done
// - busy i2c refuses requests and writes
// - buffer write starts baud generator in spi and i2c master modes
module ssc_ctrl (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire ssc_pkg::ssc_evt_t evt,
  output ssc_pkg::ssc_ctl_t      ctl,
  output logic                   tx_load,
  output logic      [7:0]        tx_data,
  output logic                   clk_tick,
  output logic                   gc_hit
);
  // ========================================================
  // helper functions
  function automatic ssc_pkg::ssc_mode_t mode_of(input logic [3:0] m);
    case (m)
      4'hF, 4'hE, 4'h7, 4'h6: mode_of = ssc_pkg::SSC_I2C_SLV;
      4'hB:                   mode_of = ssc_pkg::SSC_I2C_FW;
      4'h8:                   mode_of = ssc_pkg::SSC_I2C_MST;
      4'hA, 4'h0, 4'h1, 4'h2, 4'h3: mode_of = ssc_pkg::SSC_SPI_MST;
      4'h4, 4'h5:             mode_of = ssc_pkg::SSC_SPI_SLV;
      default:                mode_of = ssc_pkg::SSC_RSVD;
    endcase
  endfunction

  // half-period reload; brg modes count down from the address register
  function automatic logic [8:0] reload_of(input logic [3:0] m, input logic [7:0] a);
    case (m)
      4'h0:    reload_of = `SSC_RLD_DIV4;
      4'h1:    reload_of = `SSC_RLD_DIV16;
      4'h2:    reload_of = `SSC_RLD_DIV64;
      default: reload_of = {a, 1'b1};
    endcase
  endfunction

  // ========================================================
  // register state
  logic       smp_r, cke_r, da_r, p_r, s_r, rw_slv_r, ua_r, bf_r;
  logic       write_collision_r, ov_r, en_r, ckp_r;
  logic [3:0] mode_r;
  logic       general_call_enable_r, ack_received_status_r, ack_value_r, ack_sequence_start_r, master_receive_enable_r, pen_r, restart_request_r, sen_r;
  logic [7:0] buf_r, addr_r;
  logic       brg_run_r;
  logic [8:0] brg_cnt_r;

  ssc_pkg::ssc_mode_t cls;
  logic               is_i2c, is_mst_i2c, is_slv_i2c, i2c_idle;
  logic               acc, wr, rd, wr_buf, buf_blocked, rx_take, rx_over;
  logic               seq_busy, rw_view;
  logic [7:0]         wd, stat_v, con1_v, con2_v;

  assign cls        = mode_of(mode_r);
  assign is_i2c     = (cls == ssc_pkg::SSC_I2C_MST) || (cls == ssc_pkg::SSC_I2C_FW)
                      || (cls == ssc_pkg::SSC_I2C_SLV);
  assign is_mst_i2c = (cls == ssc_pkg::SSC_I2C_MST) || (cls == ssc_pkg::SSC_I2C_FW);
  assign is_slv_i2c = (cls == ssc_pkg::SSC_I2C_SLV);

  // idle test: transmit busy or any pending request means busy
  assign seq_busy = sen_r | restart_request_r | pen_r | master_receive_enable_r | ack_sequence_start_r;
  assign i2c_idle = !(evt.tx_active | seq_busy);
  assign rw_view  = is_mst_i2c ? evt.tx_active : rw_slv_r;

  // bus strobes: effects happen at the access edge only
  assign acc = psel && penable && pready;
  assign wr  = acc && pwrite;
  assign rd  = acc && !pwrite;
  assign wd  = pwdata[7:0];

  // buffer write refusal
  assign buf_blocked = (is_mst_i2c && !i2c_idle)
                       || (cls == ssc_pkg::SSC_SPI_MST && brg_run_r)
                       || ((is_slv_i2c || cls == ssc_pkg::SSC_SPI_SLV) && evt.tx_active);
  assign wr_buf  = wr && (paddr == `SSC_OFF_BUF);

  // a completed byte is lost if the buffer is unread, spi master excepted
  assign rx_over = evt.rx_done && bf_r && (cls != ssc_pkg::SSC_SPI_MST);
  assign rx_take = evt.rx_done && !rx_over;

  // read views; reserved upper bits read zero
  assign stat_v = {smp_r, cke_r, da_r, p_r, s_r, rw_view, ua_r, bf_r};
  assign con1_v = {write_collision_r, ov_r, en_r, ckp_r, mode_r};
  assign con2_v = {general_call_enable_r, ack_received_status_r, ack_value_r, ack_sequence_start_r, master_receive_enable_r, pen_r, restart_request_r, sen_r};

  // ========================================================
  // apb slave: zero wait states, answer prepared in setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          `SSC_OFF_STATUS: prdata <= {24'h00_0000, stat_v};
          `SSC_OFF_CON1:   prdata <= {24'h00_0000, con1_v};
          `SSC_OFF_CON2:   prdata <= {24'h00_0000, con2_v};
          `SSC_OFF_BUF:    prdata <= {24'h00_0000, buf_r};
          `SSC_OFF_ADDR:   prdata <= {24'h00_0000, addr_r};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // ========================================================
  // status: only sample and edge bits are writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_r <= 1'b0;
      cke_r <= 1'b0;
    end else if (wr && paddr == `SSC_OFF_STATUS) begin
      smp_r <= wd[`SSC_ST_SMP];
      cke_r <= wd[`SSC_ST_CKE];
    end
  end

  // data/address, start and stop flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      da_r <= 1'b0;
      p_r  <= 1'b0;
      s_r  <= 1'b0;
    end else if (!en_r) begin
      p_r  <= 1'b0;
      s_r  <= 1'b0;
    end else if (is_i2c) begin
      if (evt.rx_done || evt.tx_done)
        da_r <= evt.byte_is_data;
      if (evt.start_det) begin
        s_r <= 1'b1;
        p_r <= 1'b0;
      end else if (evt.stop_det) begin
        p_r <= 1'b1;
        s_r <= 1'b0;
      end
    end
  end

  // slave direction capture, void after start, stop or nack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rw_slv_r <= 1'b0;
    end else if (is_slv_i2c && evt.addr_match) begin
      rw_slv_r <= evt.rw_bit;
    end else if (evt.start_det || evt.stop_det || evt.nack_det) begin
      rw_slv_r <= 1'b0;
    end
  end

  // update-address request, cleared when software reloads the address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ua_r <= 1'b0;
    end else if (is_slv_i2c && evt.ua_need) begin
      ua_r <= 1'b1;
    end else if (wr && paddr == `SSC_OFF_ADDR) begin
      ua_r <= 1'b0;
    end
  end

  // buffer full: later terms win, so a fresh byte beats a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bf_r <= 1'b0;
    end else begin
      if (rd && paddr == `SSC_OFF_BUF)
        bf_r <= 1'b0;
      if (is_i2c && evt.tx_done)
        bf_r <= 1'b0;
      if (is_i2c && wr_buf && !buf_blocked)
        bf_r <= 1'b1;
      if (rx_take)
        bf_r <= 1'b1;
    end
  end

  // shift buffer: software load or accepted received byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_r <= `SSC_RST_BUF;
    end else if (rx_take) begin
      buf_r <= evt.rx_byte;
    end else if (wr_buf && !buf_blocked) begin
      buf_r <= wd;
    end
  end

  // ========================================================
  // control one: sticky flags clear by writing zero, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_collision_r <= 1'b0;
      ov_r   <= 1'b0;
    end else begin
      if (wr && paddr == `SSC_OFF_CON1 && !wd[`SSC_C1_WRITE_COLLISION])
        write_collision_r <= 1'b0;
      if (wr && paddr == `SSC_OFF_CON1 && !wd[`SSC_C1_OV])
        ov_r <= 1'b0;
      if (wr_buf && buf_blocked)
        write_collision_r <= 1'b1;
      if (rx_over && (is_i2c || cls == ssc_pkg::SSC_SPI_SLV))
        ov_r <= 1'b1;
    end
  end

  // enable, polarity and mode fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r   <= 1'b0;
      ckp_r  <= 1'b0;
      mode_r <= 4'h0;
    end else if (wr && paddr == `SSC_OFF_CON1) begin
      en_r   <= wd[`SSC_C1_EN];
      ckp_r  <= wd[`SSC_C1_CKP];
      mode_r <= wd[3:0];
    end
  end

  // address / baud register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= `SSC_RST_ADDR;
    end else if (wr && paddr == `SSC_OFF_ADDR) begin
      addr_r <= wd;
    end
  end

  // ========================================================
  // control two: plain bits and the ack status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_call_enable_r    <= 1'b0;
      ack_value_r   <= 1'b0;
      ack_received_status_r <= 1'b0;
    end else begin
      if (wr && paddr == `SSC_OFF_CON2) begin
        general_call_enable_r  <= wd[`SSC_C2_GENERAL_CALL_ENABLE];
        ack_value_r <= wd[`SSC_C2_ACK_VALUE];
      end
      if (is_i2c && evt.ack_seen)
        ack_received_status_r <= evt.ack_missing;
    end
  end

  // sequencing requests: in i2c master modes set by software only when idle, done clears
  // them; a done pulse beats a same-cycle write of the same bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_sequence_start_r <= 1'b0;
      master_receive_enable_r  <= 1'b0;
      pen_r   <= 1'b0;
      restart_request_r  <= 1'b0;
      sen_r   <= 1'b0;
    end else if (!en_r) begin
      ack_sequence_start_r <= 1'b0;
      master_receive_enable_r  <= 1'b0;
      pen_r   <= 1'b0;
      restart_request_r  <= 1'b0;
      sen_r   <= 1'b0;
    end else if (is_mst_i2c) begin
      if (wr && paddr == `SSC_OFF_CON2 && i2c_idle) begin
        ack_sequence_start_r <= wd[`SSC_C2_ACK_SEQUENCE_START];
        master_receive_enable_r  <= wd[`SSC_C2_MASTER_RECEIVE_ENABLE];
        pen_r   <= wd[`SSC_C2_PEN];
        restart_request_r  <= wd[`SSC_C2_RESTART_REQUEST];
        sen_r   <= wd[`SSC_C2_SEN];
      end
      if (evt.seq_done[4]) ack_sequence_start_r <= 1'b0;
      if (evt.seq_done[3]) master_receive_enable_r  <= 1'b0;
      if (evt.seq_done[2]) pen_r   <= 1'b0;
      if (evt.seq_done[1]) restart_request_r  <= 1'b0;
      if (evt.seq_done[0]) sen_r   <= 1'b0;
    end else if (wr && paddr == `SSC_OFF_CON2) begin
      sen_r <= wd[`SSC_C2_SEN];
    end
  end

  // ========================================================
  // baud generator: runs from a buffer load or a master request
  // until the engine reports the transfer finished
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brg_run_r <= 1'b0;
    end else if (!en_r || evt.xfer_done) begin
      brg_run_r <= 1'b0;
    end else if (wr_buf && !buf_blocked
                 && (cls == ssc_pkg::SSC_SPI_MST || is_mst_i2c)) begin
      brg_run_r <= 1'b1;
    end else if (is_mst_i2c && seq_busy) begin
      brg_run_r <= 1'b1;
    end
  end

  // half-period counter; zero or tiny reloads are software's problem
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brg_cnt_r <= 9'h000;
      clk_tick  <= 1'b0;
    end else if (!brg_run_r) begin
      brg_cnt_r <= reload_of(mode_r, addr_r);
      clk_tick  <= 1'b0;
    end else if (mode_r == 4'h3) begin
      clk_tick  <= evt.timer_two_pulse;
    end else if (brg_cnt_r == 9'h000) begin
      brg_cnt_r <= reload_of(mode_r, addr_r);
      clk_tick  <= 1'b1;
    end else begin
      brg_cnt_r <= brg_cnt_r - 9'h001;
      clk_tick  <= 1'b0;
    end
  end

  // ========================================================
  // event and data outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_load <= 1'b0;
      tx_data <= 8'h00;
      gc_hit  <= 1'b0;
    end else begin
      tx_load <= wr_buf && !buf_blocked;
      if (wr_buf && !buf_blocked)
        tx_data <= wd;
      gc_hit  <= is_slv_i2c && general_call_enable_r && evt.rx_done && !evt.byte_is_data
                 && (evt.rx_byte == `SSC_GC_ADDR);
    end
  end

  // control word towards engine and pin muxes, one cycle behind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= '0;
    end else begin
      ctl.mode           <= cls;
      ctl.spi_pins_en    <= en_r && (cls == ssc_pkg::SSC_SPI_MST
                                     || cls == ssc_pkg::SSC_SPI_SLV);
      ctl.ss_pin_used    <= en_r && (mode_r == 4'h4);
      ctl.i2c_pins_en    <= en_r && is_i2c;
      ctl.ten_bit        <= is_slv_i2c && mode_r[0];
      ctl.ss_irq_en      <= is_slv_i2c && mode_r[3];
      ctl.sample_at_end  <= (cls == ssc_pkg::SSC_SPI_MST) && smp_r;
      ctl.slew_limit     <= is_i2c && !smp_r;
      ctl.smbus_thresh   <= is_i2c && cke_r;
      ctl.shift_act_idle <= !is_i2c && cke_r;
      ctl.clk_idle_high  <= !is_i2c && ckp_r;
      ctl.scl_release    <= !is_slv_i2c || ckp_r;
      ctl.stretch_en     <= is_slv_i2c && sen_r;
      ctl.seq_req        <= {ack_sequence_start_r, master_receive_enable_r, pen_r, restart_request_r, sen_r} & {5{is_mst_i2c}};
      ctl.ack_value      <= ack_value_r;
    end
  end

  // ========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ov_spi_master: assert property (
    (cls == ssc_pkg::SSC_SPI_MST && evt.rx_done && bf_r) |=> !$rose(ov_r))
    else $error("overflow raised in spi master mode");
  a_ps_disabled: assert property (
    !en_r |=> (!p_r && !s_r))
    else $error("start or stop flag kept while disabled");
  a_seq_refused: assert property (
    (wr && paddr == `SSC_OFF_CON2 && is_mst_i2c && !i2c_idle && en_r
     && evt.seq_done == 5'h00) |=> $stable(master_receive_enable_r) && $stable(pen_r))
    else $error("request accepted while port busy");
  a_bf_on_rx: assert property (
    (evt.rx_done && !bf_r) |=> bf_r && buf_r == $past(evt.rx_byte))
    else $error("received byte not marked full");
  a_write_collision_blocked: assert property (
    (wr_buf && buf_blocked) |=> write_collision_r && $stable(buf_r))
    else $error("blocked write not flagged");
  a_sen_clears: assert property (
    (en_r && is_mst_i2c && sen_r && evt.seq_done[0] && !wr) |=> !sen_r)
    else $error("start request did not self-clear");
  a_gc_event: assert property (
    (is_slv_i2c && general_call_enable_r && evt.rx_done && !evt.byte_is_data
     && evt.rx_byte == `SSC_GC_ADDR) |=> gc_hit)
    else $error("general call not reported");
  a_tick_div4: assert property (
    (clk_tick && brg_run_r && mode_r == 4'h0) ##1 (brg_run_r && mode_r == 4'h0)
    |=> clk_tick)
    else $error("divide-by-four tick spacing wrong");
  a_rw_master: assert property (
    (is_mst_i2c && rd && paddr == `SSC_OFF_STATUS)
    |-> prdata[`SSC_ST_RW] == $past(evt.tx_active))
    else $error("master direction bit not transmit status");
endmodule

// ### verification/ssc_engine_model.sv
`timescale 1ns/1ns
// far-side shift engine: answers buffer loads and injects bus events
module ssc_engine_model (
  input  wire logic              pclk,
  input  wire logic              tx_load,
  input  wire ssc_pkg::ssc_ctl_t ctl,
  output ssc_pkg::ssc_evt_t      evt
);
  // declaration initialisers, so only the clocked process drives the counter
  logic [4:0]        busy_cnt = 5'h00;
  ssc_pkg::ssc_evt_t inj = '0;
  // a loaded byte keeps the shifter busy for a while; long enough for software to collide
  always @(posedge pclk) begin
    if (tx_load && (ctl.i2c_pins_en || ctl.spi_pins_en)) begin
      busy_cnt <= 5'h1F;
    end else if (busy_cnt != 5'h00) begin
      busy_cnt <= busy_cnt - 5'h01;
    end
  end
  // injected pulses are overlaid with the transmit progress
  always_comb begin
    evt = inj;
    evt.tx_active = (busy_cnt > 5'h01) | inj.tx_active;
    evt.tx_done = (busy_cnt == 5'h01);
    evt.xfer_done = (busy_cnt == 5'h01);
  end
  // one-cycle event pulse, launched just after an edge
  task automatic fire(input ssc_pkg::ssc_evt_t e);
    @(posedge pclk);
    inj <= e;
    @(posedge pclk);
    inj <= '0;
  endtask
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ns
`include "ssc_defs.svh"
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_load, last_err;
  logic clk_tick, gc_hit;
  logic [7:0]        tx_data;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic [7:0]        q;
  ssc_pkg::ssc_evt_t evt, e;
  ssc_pkg::ssc_ctl_t ctl;
  int                n_mismatch, tests_run, cyc;
  ssc_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(evt), .ctl(ctl), .tx_load(tx_load), .tx_data(tx_data),
    .clk_tick(clk_tick), .gc_hit(gc_hit));
  ssc_engine_model u_eng (.pclk(pclk), .tx_load(tx_load), .ctl(ctl), .evt(evt));
  // =======================================================
  // clock, timeout and verdict
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // =======================================================
  // apb transfer; one idle edge first so no signal is driven twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // masked read compare
  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(q & m, exp);
  endtask
  // =======================================================
  // main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    n_mismatch = 0; tests_run = 0; cyc = 0; e = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SSC_OFF_STATUS, 8'hFF, 8'h00);
    rd(`SSC_OFF_CON1, 8'hFF, 8'h00);
    rd(`SSC_OFF_CON2, 8'hFF, 8'h00);
    rd(12'h020, 8'hFF, 8'h00);
    chk({7'h00, last_err}, 8'h01);
    apb(1'b1, `SSC_OFF_STATUS, 8'hFF);
    rd(`SSC_OFF_STATUS, 8'hFF, 8'hC0);
    chk({6'h00, ctl.sample_at_end, ctl.shift_act_idle}, 8'h03);
    // spi master at the fastest divisor: the tick toggles every clock
    apb(1'b1, `SSC_OFF_CON1, 8'h20);
    apb(1'b1, `SSC_OFF_BUF, 8'h11);
    repeat (3) @(negedge pclk);
    q = {7'h00, clk_tick};
    @(negedge pclk);
    chk({7'h00, q[0] ^ clk_tick}, 8'h01);
    chk(tx_data, 8'h11);
    // let the model finish its shift before changing mode
    repeat (40) @(posedge pclk);
    // i2c master with a legal baud value
    apb(1'b1, `SSC_OFF_ADDR, 8'h09);
    apb(1'b1, `SSC_OFF_CON1, 8'h28);
    // control word lags the register by one clock
    repeat (2) @(posedge pclk);
    chk({7'h00, ctl.i2c_pins_en}, 8'h01);
    chk({5'h00, ctl.mode}, {5'h00, ssc_pkg::SSC_I2C_MST});
    apb(1'b1, `SSC_OFF_CON2, 8'h01);
    rd(`SSC_OFF_CON2, 8'h01, 8'h01);
    e.seq_done = 5'h01;
    e.start_det = 1'b1;
    u_eng.fire(e);
    rd(`SSC_OFF_CON2, 8'h01, 8'h00);
    rd(`SSC_OFF_STATUS, 8'h18, 8'h08);
    // busy transmit refuses requests and a second buffer write
    apb(1'b1, `SSC_OFF_BUF, 8'hA5);
    apb(1'b1, `SSC_OFF_CON2, 8'h04);
    chk(tx_data, 8'hA5);
    rd(`SSC_OFF_CON2, 8'h04, 8'h00);
    rd(`SSC_OFF_STATUS, 8'h04, 8'h04);
    apb(1'b1, `SSC_OFF_BUF, 8'h3C);
    rd(`SSC_OFF_CON1, 8'h80, 8'h80);
    apb(1'b1, `SSC_OFF_CON1, 8'h28);
    rd(`SSC_OFF_CON1, 8'h80, 8'h00);
    repeat (20) @(posedge pclk);
    e = '0;
    e.stop_det = 1'b1;
    u_eng.fire(e);
    rd(`SSC_OFF_STATUS, 8'h18, 8'h10);
    apb(1'b1, `SSC_OFF_CON1, 8'h08);
    rd(`SSC_OFF_STATUS, 8'h18, 8'h00);
    chk({7'h00, ctl.i2c_pins_en}, 8'h00);
    // overflow drops the newer byte: spi slave, then i2c slave
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `SSC_OFF_CON1, i == 0 ? 8'h24 : 8'h26);
      apb(1'b0, `SSC_OFF_BUF, 8'h00);
      e = '0;
      e.rx_done = 1'b1;
      e.byte_is_data = 1'b1;
      e.rx_byte = 8'h5A;
      u_eng.fire(e);
      rd(`SSC_OFF_STATUS, 8'h01, 8'h01);
      e.rx_byte = 8'hC3;
      u_eng.fire(e);
      rd(`SSC_OFF_CON1, 8'h40, 8'h40);
      rd(`SSC_OFF_BUF, 8'hFF, 8'h5A);
    end
    rd(`SSC_OFF_STATUS, 8'h20, 8'h20);
    // i2c slave: clock held low, smbus thresholds on, slew limit off
    chk({5'h00, ctl.scl_release, ctl.smbus_thresh, ctl.slew_limit}, 8'h02);
    // general call address with the enable set
    apb(1'b1, `SSC_OFF_CON2, 8'h80);
    e = '0;
    e.rx_done = 1'b1;
    u_eng.fire(e);
    @(negedge pclk);
    chk({7'h00, gc_hit}, 8'h01);
    rd(`SSC_OFF_STATUS, 8'h21, 8'h01);
    report_and_stop();
  end
endmodule
